/* rtl/loopback_path_router.sv */
// Loopback and port routing control with an APB register slave.
//
// How it works
// (RULE1) Loop 1 bit sends XAUI receive straight to XAUI transmit, no clock recovery.
// (RULE2) Strap 1 with loop 1 also carries XAUI ingress on to XFI egress.
// (RULE3) Loop 2 bit turns XFI ingress around at the PHY-XS, 10G retimed.
// (RULE4) Loop 2 also copies XFI ingress to XAUI egress.
// (RULE5) Near pin high enables loops 1 and 2; pull-down keeps them off.
// (RULE6) Strap 1 at reset sets mux a and b to 0, XGMII outputs static.
// (RULE7) Strap 0 at reset sets mux a and b to 1 and output enable to 1.
// (RULE8) Mux a, mux b and output enable stay writable after reset.
// (RULE9) Only loop pairs 1-2 and 6-7 have pins; all else is registers.
// (RULE10) XFI ingress reaches XGMII with strap 0, or strap 1 and loop 3.
// (RULE11) Software mirrors XFI to XGMII and XFI via strap 1, loop 3, OE.
// (RULE12) Loop 4 bit loops XGMII ingress to egress while mirroring to XAUI.
// (RULE13) Loop 5 loops through PCS: XAUI with strap 1, XGMII with strap 0.
// (RULE14) Software mirrors XGMII via PCS with strap 1, mux a, loop 5, OE.
// (RULE15) Loop 6 loops through PCS and PMA: XAUI strap 1, XGMII strap 0.
// (RULE16) Loop 6 also carries XAUI input on to the XFI serial output.
// (RULE17) Software mirrors XGMII via PCS and PMA with strap 1, mux a, loop 6, OE.
// (RULE18) Loop 7 bit is active low, loops XFI through the 16 bit interface.
// (RULE19) Far pin low enables loops 6 and 7; pull-up keeps them off.
// (RULE20) Loop 6 retimes via rate compensation on refclk; loop 7 uses 10G clock.
// (RULE21) A loop is enabled when either its pin or its register asks.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module loopback_path_router (
   input  wire logic                        clk_sys,
   input  wire logic                        reset,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [loopback_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        near_loop_pair_enable,
   input  wire logic                        far_loop_pair_enable_low,
   input  wire logic                        io_config_strap,
   output loopback_pkg::route_t             route,
   output logic                             mux_a,
   output logic                             mux_b,
   output logic                             xgmii_oe,
   output logic                             strap_latched
);
   import loopback_pkg::*;

   if (ADDR_W < IDX_W + 2) begin : g_addr_check
      $error("address too narrow for register indices");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and strap capture.

   logic [2:0] pin_raw;
   logic [2:0] pin_sync_w;
   logic       near_s;
   logic       far_n_s;
   logic       strap_s;

   assign pin_raw = {io_config_strap, far_loop_pair_enable_low, near_loop_pair_enable};

   // During reset the synchronisers hold the idle pin levels, so release shows no false enable.
   pin_sync #(.W(3), .RST_VAL({STRAP_RST, FAR_PIN_RST, NEAR_PIN_RST})) u_sync (
      .clk_sys (clk_sys),
      .reset   (reset),
      .pin     (pin_raw),
      .sync    (pin_sync_w)
   );
   assign near_s  = pin_sync_w[0];
   assign far_n_s = pin_sync_w[1];
   assign strap_s = pin_sync_w[2];

   // The strap is taken only once the synchroniser has seen the pin after release.
   logic [1:0] wait_ff;
   logic [1:0] nxt_wait;
   logic       strap_ff;
   logic       nxt_strap;
   logic       capture;

   ////////////////////////////////////////////////////////////////////////////////
   // Register file and APB slave.

   logic [7:1] lb_reg_ff;
   logic [7:1] nxt_lb_reg;
   logic       mux_a_ff;
   logic       nxt_mux_a;
   logic       mux_b_ff;
   logic       nxt_mux_b;
   logic       oe_ff;
   logic       nxt_oe;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic       pready_ff;
   logic       nxt_pready;
   logic       pslverr_ff;
   logic       nxt_pslverr;
   logic [7:1] lb_eff;
   logic [IDX_W-1:0] idx;
   logic       hit;
   logic [31:0] rd_word;
   logic       wr_go;
   route_t     route_ff;
   route_if    rif ();

   assign idx = paddr[IDX_W+1:2];
   assign capture = (wait_ff == 2'h1);
   assign wr_go = psel & penable & pready_ff & pwrite & ~pslverr_ff;

   // Pins and bits are or-ed; loop 7 bit and the far pin are both active low.
   assign lb_eff[1] = lb_reg_ff[1] | near_s; // (RULE5) (RULE21)
   assign lb_eff[2] = lb_reg_ff[2] | near_s; // (RULE5) (RULE21)
   assign lb_eff[3] = lb_reg_ff[3]; // (RULE9)
   assign lb_eff[4] = lb_reg_ff[4]; // (RULE9)
   assign lb_eff[5] = lb_reg_ff[5]; // (RULE9)
   assign lb_eff[6] = lb_reg_ff[6] | ~far_n_s; // (RULE19) (RULE21)
   assign lb_eff[7] = ~lb_reg_ff[7] | ~far_n_s; // (RULE18) (RULE19) (RULE21)

   always_comb begin
      hit = 1'b1;
      rd_word = '0;
      unique case (idx)
         IDX_PHYXS_LOOP1: rd_word[BIT_LB1] = lb_reg_ff[1];
         IDX_PHYXS_CTRL1: rd_word[BIT_LB2] = lb_reg_ff[2];
         IDX_PHYXS_LOOP3: rd_word[BIT_LB3] = lb_reg_ff[3];
         IDX_PCS_CTRL1:   rd_word[BIT_LB4] = lb_reg_ff[4];
         IDX_PCS_VS: begin
            rd_word[BIT_LB5]  = lb_reg_ff[5];
            rd_word[BIT_OE]   = oe_ff;
            rd_word[BIT_MUXA] = mux_a_ff;
         end
         IDX_MUXB:        rd_word[BIT_MUXB] = mux_b_ff;
         IDX_PMA_CTRL1:   rd_word[BIT_LB6] = lb_reg_ff[6];
         IDX_PMA_VS:      rd_word[BIT_LB7N] = lb_reg_ff[7];
         IDX_STATUS: begin
            rd_word[ST_STRAP] = strap_ff;
            rd_word[ST_NEAR]  = near_s;
            rd_word[ST_FAR_N] = far_n_s;
            rd_word[ST_LB_LO +: 7] = lb_eff;
         end
         default:         hit = 1'b0;
      endcase
   end

   always_comb begin
      nxt_wait    = (wait_ff != 2'h0) ? wait_ff - 2'h1 : wait_ff;
      nxt_strap   = capture ? strap_s : strap_ff;
      nxt_lb_reg  = lb_reg_ff;
      nxt_mux_a   = mux_a_ff;
      nxt_mux_b   = mux_b_ff;
      nxt_oe      = oe_ff;
      // Answer in the first access cycle; data is sampled during setup.
      nxt_pready  = psel & ~penable;
      nxt_pslverr = psel & ~penable & ~hit;
      nxt_prdata  = (psel & ~penable & ~pwrite) ? rd_word : prdata_ff;
      if (capture) begin
         nxt_mux_a = ~strap_s; // (RULE6) (RULE7)
         nxt_mux_b = ~strap_s; // (RULE6) (RULE7)
         nxt_oe    = ~strap_s; // (RULE6) (RULE7)
      end
      // A write in the capture cycle wins, as software owns these after reset.
      if (wr_go) begin
         unique case (idx)
            IDX_PHYXS_LOOP1: nxt_lb_reg[1] = pwdata[BIT_LB1]; // (RULE1)
            IDX_PHYXS_CTRL1: nxt_lb_reg[2] = pwdata[BIT_LB2]; // (RULE3)
            IDX_PHYXS_LOOP3: nxt_lb_reg[3] = pwdata[BIT_LB3]; // (RULE10)
            IDX_PCS_CTRL1:   nxt_lb_reg[4] = pwdata[BIT_LB4]; // (RULE12)
            IDX_PCS_VS: begin
               nxt_lb_reg[5] = pwdata[BIT_LB5]; // (RULE13)
               nxt_oe        = pwdata[BIT_OE]; // (RULE8)
               nxt_mux_a     = pwdata[BIT_MUXA]; // (RULE8)
            end
            IDX_MUXB:        nxt_mux_b = pwdata[BIT_MUXB]; // (RULE8)
            IDX_PMA_CTRL1:   nxt_lb_reg[6] = pwdata[BIT_LB6]; // (RULE15)
            IDX_PMA_VS:      nxt_lb_reg[7] = pwdata[BIT_LB7N]; // (RULE18)
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wait_ff    <= STRAP_WAIT + 2'h1;
         strap_ff   <= STRAP_RST;
         lb_reg_ff  <= {LB7N_RST, {6{LB_RST}}};
         mux_a_ff   <= 1'b0;
         mux_b_ff   <= 1'b0;
         oe_ff      <= 1'b0;
         prdata_ff  <= '0;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         wait_ff    <= nxt_wait;
         strap_ff   <= nxt_strap;
         lb_reg_ff  <= nxt_lb_reg;
         mux_a_ff   <= nxt_mux_a;
         mux_b_ff   <= nxt_mux_b;
         oe_ff      <= nxt_oe;
         prdata_ff  <= nxt_prdata;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Path selection, registered so the route outputs are glitch free.

   assign rif.lb_en = lb_eff;
   assign rif.strap = strap_ff;
   assign rif.mux_a = mux_a_ff;
   assign rif.mux_b = mux_b_ff;

   path_select u_sel (
      .rif (rif.sel)
   );

   // Registering the decode costs one cycle of latency on every path change.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         route_ff <= '0;
      end else begin
         route_ff <= rif.route;
      end
   end

   assign route         = route_ff;
   assign mux_a         = mux_a_ff;
   assign mux_b         = mux_b_ff;
   assign xgmii_oe      = oe_ff;
   assign strap_latched = strap_ff;
   assign prdata        = prdata_ff;
   assign pready        = pready_ff;
   assign pslverr       = pslverr_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_strap_one_defaults: assert property (capture && strap_s && !wr_go |=> // (RULE6)
      !mux_a_ff && !mux_b_ff && !oe_ff) else $error("strap 1 defaults wrong");
   a_strap_zero_defaults: assert property (capture && !strap_s && !wr_go |=> // (RULE7)
      mux_a_ff && mux_b_ff && oe_ff) else $error("strap 0 defaults wrong");
   a_mux_a_write: assert property (wr_go && idx == IDX_PCS_VS |=> // (RULE8)
      mux_a_ff == $past(pwdata[BIT_MUXA]) && oe_ff == $past(pwdata[BIT_OE]))
      else $error("mux a write lost");
   a_near_pin_pair: assert property (near_s ##1 near_s |=> // (RULE5)
      route.xaui_raw_loop && route.xfi_phyxs_loop) else $error("near pin loops off");
   a_far_pin_pair: assert property (!far_n_s ##1 !far_n_s |=> // (RULE19)
      route.xsbi_loop && route.rate_comp_refclk) else $error("far pin loops off");
   a_loop7_low: assert property (!lb_reg_ff[7] |=> route.xsbi_loop) // (RULE18)
      else $error("loop 7 not active low");
   a_pcs_loop_strap: assert property (lb_reg_ff[5] |=> // (RULE13)
      route.pcs_loop_xaui == $past(strap_ff) && route.pcs_loop_xgmii == !$past(strap_ff))
      else $error("pcs loop side wrong");
   a_pma_loop_strap: assert property (lb_reg_ff[6] |=> // (RULE15)
      route.pma_loop_xaui == $past(strap_ff) && route.xaui_to_xfi)
      else $error("pma loop side wrong");
   a_xfi_to_xgmii: assert property (!strap_ff |=> route.xfi_to_xgmii) // (RULE10)
      else $error("xfi to xgmii missing");
   a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("apb answer timing");

   // Route checks look one edge on, because route is the registered decode.
   a_loop1_raw: assert property (lb_eff[1] |=> // (RULE1)
      route.xaui_raw_loop) else $error("loop 1 raw path off");
   a_loop1_to_xfi: assert property (lb_eff[1] && strap_ff |=> // (RULE2)
      route.xaui_to_xfi) else $error("loop 1 xfi copy off");
   a_loop2_mirror: assert property (lb_eff[2] |=> // (RULE4)
      route.xfi_phyxs_loop && route.xfi_to_xaui && route.retime_10g)
      else $error("loop 2 mirror off");
   a_loop3_xgmii: assert property (lb_eff[3] && strap_ff |=> // (RULE10)
      route.xfi_to_xgmii && route.xgmii_loop) else $error("loop 3 xgmii copy off");
   a_loop4_mirror: assert property (lb_reg_ff[4] |=> // (RULE12)
      route.xgmii_loop && route.xgmii_to_xaui) else $error("loop 4 mirror off");
   a_loop6_xfi: assert property (lb_eff[6] |=> // (RULE16)
      route.xaui_to_xfi && route.rate_comp_refclk) else $error("loop 6 xfi copy off");
   a_loop7_retime: assert property (lb_eff[7] |=> // (RULE20)
      route.xsbi_loop && route.retime_10g) else $error("loop 7 retime off");

   // The pins must never reach a loop that only a register may enable.
   a_pins_pairs_only: assert property (lb_reg_ff[5:3] == 3'h0 |=> // (RULE9)
      !route.xgmii_loop && !route.pcs_loop_xaui && !route.pcs_loop_xgmii)
      else $error("pin reached a register loop");
   a_strap_held: assert property (capture |=> // (RULE6)
      strap_latched == $past(strap_s)) else $error("strap not latched");
   a_mux_b_write: assert property (wr_go && idx == IDX_MUXB |=> // (RULE8)
      mux_b_ff == $past(pwdata[BIT_MUXB]))
      else $error("mux b write lost");

   // A refused transfer must neither change a loop bit nor return stale data.
   a_refused_write: assert property (psel && penable && pready && pslverr |=>
      $stable(lb_reg_ff)) else $error("refused write landed");
   a_refused_read: assert property (psel && !penable && !hit && !pwrite |=>
      pslverr && prdata == 32'h0) else $error("refused read wrong");

   c_near_pair: cover property (near_s ##2 route.xfi_to_xaui);
   c_far_pair: cover property (!far_n_s ##2 route.rate_comp_refclk);
   c_pcs_mirror: cover property (strap_ff && mux_a_ff && lb_reg_ff[5] && oe_ff);
   c_bad_addr: cover property (pready && pslverr);
   c_strap_zero: cover property (capture && !strap_s);
endmodule : loopback_path_router
`default_nettype wire

/* rtl/loopback_pkg.sv */
// Constants and types shared by the loopback path router.
`default_nettype none
package loopback_pkg;
   // Register indices, written as the management device and register number.
   localparam int unsigned IDX_W = 19;
   localparam int unsigned ADDR_W = 21;
   localparam logic [IDX_W-1:0] IDX_PMA_CTRL1 = 19'h10000;
   localparam logic [IDX_W-1:0] IDX_PMA_VS = 19'h18000;
   localparam logic [IDX_W-1:0] IDX_PCS_CTRL1 = 19'h30000;
   localparam logic [IDX_W-1:0] IDX_PCS_VS = 19'h38005;
   localparam logic [IDX_W-1:0] IDX_MUXB = 19'h38006;
   localparam logic [IDX_W-1:0] IDX_STATUS = 19'h38007;
   localparam logic [IDX_W-1:0] IDX_PHYXS_CTRL1 = 19'h40000;
   localparam logic [IDX_W-1:0] IDX_PHYXS_LOOP1 = 19'h4800E;
   localparam logic [IDX_W-1:0] IDX_PHYXS_LOOP3 = 19'h4800F;

   // Bit positions inside those registers.
   localparam int unsigned BIT_LB1 = 13;
   localparam int unsigned BIT_LB2 = 14;
   localparam int unsigned BIT_LB3 = 1;
   localparam int unsigned BIT_LB4 = 14;
   localparam int unsigned BIT_LB5 = 2;
   localparam int unsigned BIT_OE = 6;
   localparam int unsigned BIT_MUXA = 8;
   localparam int unsigned BIT_MUXB = 0;
   localparam int unsigned BIT_LB6 = 0;
   localparam int unsigned BIT_LB7N = 8;

   // Status word layout: strap, near pin, far pin (low active), loop enables.
   localparam int unsigned ST_STRAP = 0;
   localparam int unsigned ST_NEAR = 1;
   localparam int unsigned ST_FAR_N = 2;
   localparam int unsigned ST_LB_LO = 3;

   // Values after reset.
   localparam logic LB_RST = 1'b0;
   localparam logic LB7N_RST = 1'b1;
   localparam logic NEAR_PIN_RST = 1'b0;
   localparam logic FAR_PIN_RST = 1'b1;
   localparam logic STRAP_RST = 1'b1;
   localparam logic [1:0] STRAP_WAIT = 2'h2;

   typedef struct packed {
      logic xaui_raw_loop;
      logic xaui_to_xfi;
      logic xfi_phyxs_loop;
      logic xfi_to_xaui;
      logic xfi_to_xgmii;
      logic xgmii_loop;
      logic xgmii_to_xaui;
      logic pcs_loop_xaui;
      logic pcs_loop_xgmii;
      logic pma_loop_xaui;
      logic pma_loop_xgmii;
      logic xsbi_loop;
      logic rate_comp_refclk;
      logic retime_10g;
   } route_t;
endpackage : loopback_pkg
`default_nettype wire

/* rtl/path_select.sv */
// Decodes loop enables and the strap into data path routing selects.
`timescale 1ns/1ps
`default_nettype none
module path_select (
   route_if.sel rif
);
   import loopback_pkg::*;

   always_comb begin
      rif.route = '0;
      rif.route.xaui_raw_loop = rif.lb_en[1]; // (RULE1)
      // XAUI reaches XFI on the normal mux setting, through loop 1 under strap, or loop 6.
      rif.route.xaui_to_xfi = ~rif.mux_a | (rif.lb_en[1] & rif.strap) // (RULE2)
         | rif.lb_en[6]; // (RULE16)
      rif.route.xfi_phyxs_loop = rif.lb_en[2]; // (RULE3)
      rif.route.xfi_to_xaui = rif.lb_en[2]; // (RULE4)
      rif.route.xfi_to_xgmii = (rif.lb_en[3] & rif.strap) | ~rif.strap; // (RULE10)
      rif.route.xgmii_loop = rif.lb_en[3] | rif.lb_en[4]; // (RULE12)
      rif.route.xgmii_to_xaui = rif.lb_en[4] | (rif.mux_a & rif.strap); // (RULE12)
      rif.route.pcs_loop_xaui = rif.lb_en[5] & rif.strap; // (RULE13)
      rif.route.pcs_loop_xgmii = rif.lb_en[5] & ~rif.strap; // (RULE13)
      rif.route.pma_loop_xaui = rif.lb_en[6] & rif.strap; // (RULE15)
      rif.route.pma_loop_xgmii = rif.lb_en[6] & ~rif.strap; // (RULE15)
      rif.route.xsbi_loop = rif.lb_en[7]; // (RULE18)
      rif.route.rate_comp_refclk = rif.lb_en[6]; // (RULE20)
      rif.route.retime_10g = rif.lb_en[2] | rif.lb_en[3] | rif.lb_en[7]; // (RULE20)
   end
endmodule : path_select
`default_nettype wire

/* rtl/pin_sync.sv */
// Two flip-flop synchroniser for asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk_sys,
   input  wire logic         reset,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] sync
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   if (W < 1) begin : g_width_check
      $error("pin_sync needs W of at least one");
   end

   // Reset to the pull value so an undriven pin reads as idle.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= pin;
         sync_ff <= meta_ff;
      end
   end
   assign sync = sync_ff;
endmodule : pin_sync
`default_nettype wire

/* rtl/route_if.sv */
// Carrier between the register side and the path selection logic.
`timescale 1ns/1ps
`default_nettype none
interface route_if;
   import loopback_pkg::*;
   logic [7:1] lb_en;
   logic       strap;
   logic       mux_a;
   logic       mux_b;
   route_t     route;
   modport ctrl (output lb_en, output strap, output mux_a, output mux_b, input route);
   modport sel (input lb_en, input strap, input mux_a, input mux_b, output route);
endinterface : route_if
`default_nettype wire

/* tb/loopback_path_router_tb.sv */
// Self-checking bench for the loopback path router over APB.
`timescale 1ns/1ps
`default_nettype none
module loopback_path_router_tb;
   import loopback_pkg::*;
   logic              clk_sys = 1'b0;
   logic              reset = 1'b1;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              near_drv = 1'b0;
   logic              near_on = 1'b0;
   logic              far_drv = 1'b1;
   logic              far_on = 1'b0;
   logic              strap_drv = 1'b1;
   wire logic         near_pin;
   wire logic         far_pin_low;
   wire logic         strap_pin;
   route_t            route;
   logic              mux_a;
   logic              mux_b;
   logic              xgmii_oe;
   logic              strap_latched;
   int                err_total = 0;
   int                tests_run = 0;
   logic              s;
   logic              ma;
   logic              mb;
   logic              oe;
   logic [7:1]        lb;
   logic [31:0]       rd;
   logic              se;

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   pin_partner pin_partner_i (
      .near_drv    (near_drv),
      .near_on     (near_on),
      .far_drv     (far_drv),
      .far_on      (far_on),
      .strap_drv   (strap_drv),
      .near_pin    (near_pin),
      .far_pin_low (far_pin_low),
      .strap_pin   (strap_pin)
   );

   loopback_path_router loopback_path_router_i (
      .clk_sys                  (clk_sys),
      .reset                    (reset),
      .psel                     (psel),
      .penable                  (penable),
      .pwrite                   (pwrite),
      .paddr                    (paddr),
      .pwdata                   (pwdata),
      .prdata                   (prdata),
      .pready                   (pready),
      .pslverr                  (pslverr),
      .near_loop_pair_enable    (near_pin),
      .far_loop_pair_enable_low (far_pin_low),
      .io_config_strap          (strap_pin),
      .route                    (route),
      .mux_a                    (mux_a),
      .mux_b                    (mux_b),
      .xgmii_oe                 (xgmii_oe),
      .strap_latched            (strap_latched)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task end_sim();
      if (err_total == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         err_total++;
         $display("mismatch at %0t: no pready", $time);
         end_sim();
      end
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Reads one register and checks both its word and a clean response.
   task rdchk(input logic [IDX_W-1:0] idx, input logic [31:0] exp, input string what);
      apb(1'b0, idx, 32'h0);
      chk(rd, exp, what);
      chk({31'h0, se}, 32'h0, what);
   endtask : rdchk

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:1] eff();
      logic [7:1] l;
      l = lb;
      l[2:1] = lb[2:1] | {2{near_on & near_drv}};
      l[7:6] = lb[7:6] | {2{far_on & ~far_drv}};
      return l;
   endfunction : eff

   function automatic route_t exp_route();
      route_t     r;
      logic [7:1] l;
      l = eff();
      r.xaui_raw_loop = l[1];
      r.xaui_to_xfi = ~ma | (l[1] & s) | l[6];
      r.xfi_phyxs_loop = l[2];
      r.xfi_to_xaui = l[2];
      r.xfi_to_xgmii = ~s | (l[3] & s);
      r.xgmii_loop = l[3] | l[4];
      r.xgmii_to_xaui = l[4] | (ma & s);
      r.pcs_loop_xaui = l[5] & s;
      r.pcs_loop_xgmii = l[5] & ~s;
      r.pma_loop_xaui = l[6] & s;
      r.pma_loop_xgmii = l[6] & ~s;
      r.xsbi_loop = l[7];
      r.rate_comp_refclk = l[6];
      r.retime_10g = l[2] | l[3] | l[7];
      return r;
   endfunction : exp_route

   // Writes every control register from the bench's own copy of the settings.
   task sync_regs();
      apb(1'b1, IDX_PHYXS_LOOP1, 32'(lb[1]) << BIT_LB1);
      apb(1'b1, IDX_PHYXS_CTRL1, 32'(lb[2]) << BIT_LB2);
      apb(1'b1, IDX_PHYXS_LOOP3, 32'(lb[3]) << BIT_LB3);
      apb(1'b1, IDX_PCS_CTRL1, 32'(lb[4]) << BIT_LB4);
      apb(1'b1, IDX_PCS_VS, (32'(lb[5]) << BIT_LB5) | (32'(oe) << BIT_OE) | (32'(ma) << BIT_MUXA));
      apb(1'b1, IDX_MUXB, 32'(mb) << BIT_MUXB);
      apb(1'b1, IDX_PMA_CTRL1, 32'(lb[6]) << BIT_LB6);
      apb(1'b1, IDX_PMA_VS, 32'(!lb[7]) << BIT_LB7N);
   endtask : sync_regs

   // Four edges covers the slowest path, a pin through its synchroniser.
   task settle();
      repeat (4) @(posedge clk_sys);
      #1;
      chk({18'h0, route}, {18'h0, exp_route()}, "route");
      chk({28'h0, strap_latched, mux_a, mux_b, xgmii_oe}, {28'h0, s, ma, mb, oe}, "mux");
      apb(1'b0, IDX_STATUS, 32'h0);
      chk(rd, {22'h0, eff(), ~(far_on & ~far_drv), near_on & near_drv, s}, "status");
      apb(1'b0, IDX_PCS_VS, 32'h0);
      chk(rd, (32'(lb[5]) << BIT_LB5) | (32'(oe) << BIT_OE) | (32'(ma) << BIT_MUXA), "pcs");
      apb(1'b0, IDX_PMA_VS, 32'h0);
      chk(rd, 32'(!lb[7]) << BIT_LB7N, "lb7");
      rdchk(IDX_PHYXS_LOOP1, 32'(lb[1]) << BIT_LB1, "lb1");
      rdchk(IDX_PHYXS_CTRL1, 32'(lb[2]) << BIT_LB2, "lb2");
      rdchk(IDX_PHYXS_LOOP3, 32'(lb[3]) << BIT_LB3, "lb3");
      rdchk(IDX_PCS_CTRL1, 32'(lb[4]) << BIT_LB4, "lb4");
      rdchk(IDX_PMA_CTRL1, 32'(lb[6]) << BIT_LB6, "lb6");
      rdchk(IDX_MUXB, 32'(mb) << BIT_MUXB, "mux b");
   endtask : settle

   task do_reset(input logic strap);
      strap_drv <= strap;
      reset <= 1'b1;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (2) @(posedge clk_sys);
      s = strap;
      ma = ~strap;
      mb = ~strap;
      oe = ~strap;
      lb = '0;
   endtask : do_reset

   task run_loops();
      for (int i = 1; i <= 7; i++) begin
         lb = '0;
         lb[i] = 1'b1;
         sync_regs();
         settle();
      end
      lb = '0;
      sync_regs();
      settle();
   endtask : run_loops

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset(1'b1);
      settle();
      run_loops();
      apb(1'b1, 19'h20000, 32'hFFFFFFFF);
      chk({31'h0, se}, 32'h1, "write refused");
      apb(1'b0, 19'h20000, 32'h0);
      chk({se, rd[30:0]}, 32'h80000000, "read refused");
      near_on <= 1'b1;
      near_drv <= 1'b1;
      settle();
      lb[2] = 1'b1;
      sync_regs();
      settle();
      near_on <= 1'b0;
      settle();
      far_on <= 1'b1;
      far_drv <= 1'b0;
      settle();
      far_on <= 1'b0;
      lb = '0;
      sync_regs();
      settle();
      ma = 1'b1;
      mb = 1'b1;
      oe = 1'b1;
      sync_regs();
      settle();
      ma = 1'b0;
      mb = 1'b0;
      lb[3] = 1'b1;
      sync_regs();
      settle();
      lb = '0;
      ma = 1'b1;
      lb[5] = 1'b1;
      sync_regs();
      settle();
      lb[5] = 1'b0;
      lb[6] = 1'b1;
      sync_regs();
      settle();
      do_reset(1'b0);
      settle();
      run_loops();
      end_sim();
   end
endmodule : loopback_path_router_tb
`default_nettype wire

/* tb/pin_partner.sv */
// Far side model of the loop pins and the strap, with on-chip pull levels.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
   input  wire logic near_drv,
   input  wire logic near_on,
   input  wire logic far_drv,
   input  wire logic far_on,
   input  wire logic strap_drv,
   output logic      near_pin,
   output logic      far_pin_low,
   output logic      strap_pin
);
   // A released pin goes to its pull level, never keeps the last driven value.
   assign near_pin    = near_on ? near_drv : 1'b0;
   assign far_pin_low = far_on ? far_drv : 1'b1;
   assign strap_pin   = strap_drv;
endmodule : pin_partner
`default_nettype wire
